// File: src/memory_lock_defines.vh
`ifndef MEMORY_LOCK_DEFINES_VH
`define MEMORY_LOCK_DEFINES_VH
// Contract
// [RL1] Blocks 4 to 63 are HF user data, write-lockable for HF writes; the code group-locks only blocks 16 to 79.
// [RL2] Blocks 64 to 79 hold mapped UHF memory, protected like user data.
// [RL3] Group locks gate HF writes only; UHF writes refused by share write lock.
// [RL4] HF writes configuration word only when secure and failure limit nonzero.
// [RL5] Failure limit zero disables login counter; 1 to 7 sets maximum attempts.
// [RL6] Config byte 0 holds four lock-action pairs; nonzero pairs are frozen.
// [RL7] Config byte 1 shows killed state in bit 7; read-only.
// [RL8] Config byte 3 bit 7 is the far-field power indicator.
// [RL9] Power indicator clears when the chip powers down.
// [RL10] Power indicator sets when the configuration word is read.
// [RL11] Byte 3 permalock flags, bits 6..2 or 6..5, cannot be cleared by HF.
// [RL12] Group lock bits are one-way; a set bit never returns to zero.
// [RL13] Lock bytes 0 and 1: each bit write-protects one four-block group.
// [RL14] Lock byte 2: each bit freezes group-lock bits of one eight-block span.
// [RL15] Password region word takes effect only after the next power-up.
// [RL16] UHF writes of region word blocked only by its share write lock.
// [RL17] Exempt flag 0 protects mapped area by password; 1 exempts it.
// [RL18] Start block 00h to 7Fh marks password protection outside secure state.
// [RL19] Select 0 guards writes only; 1 guards reads and writes.
// [RL20] Password protection never restricts UHF; only share locks do.
// [RL21] All conditions combine before a write; blocked writes change nothing.

// Block map
`define USER_FIRST_BLOCK      7'h04
`define USER_LAST_BLOCK       7'h4F
`define MAPPED_FIRST_BLOCK    7'h40
`define GROUP_FIRST_BLOCK     7'h10
`define CFG_WORD_BLOCK        7'h50
`define LOCK_WORD_BLOCK       7'h51
`define REGION_WORD_BLOCK     7'h52

// Configuration word fields
`define CFG_KILLED_BIT        15
`define CFG_POWER_BIT         31
`define CFG_PERMA_SHORT_MASK  8'h7C
`define CFG_PERMA_LARGE_MASK  8'h60

// Region word fields
`define REGION_EXEMPT_BIT     31
`define REGION_START_HI       30
`define REGION_START_LO       24

// Reset values
`define CFG_RESET             32'h0000_0000
`define LOCK_RESET            32'h0000_0000
`define REGION_RESET          32'hFF00_0000
`endif

// File: src/dual_interface_memory_lock.v
`timescale 1ns/1ns
`include "memory_lock_defines.vh"

module dual_interface_memory_lock #(
  parameter LARGE_MEM    = 0,
  parameter SHARE_GROUPS = 19
) (
  input  wire                    SYS_CLK,
  input  wire                    RESET_N,
  input  wire                    REQ,
  input  wire                    REQ_UHF,
  input  wire                    REQ_WRITE,
  input  wire [6:0]              REQ_BLOCK,
  input  wire [31:0]             REQ_WDATA,
  input  wire                    HF_SECURE,
  input  wire [2:0]              LOGIN_FAILURE_LIMIT,
  input  wire                    PROTECT_READ_WRITE_SELECT,
  input  wire                    CONFIG_WORDS_LOCK,
  input  wire                    KILLED,
  input  wire [SHARE_GROUPS-1:0] UHF_SIDE_WRITE_SHARE_LOCK,
  input  wire [SHARE_GROUPS-1:0] UHF_SIDE_READ_SHARE_LOCK,
  input  wire                    CFG0_SHARE_WRITE_LOCK,
  input  wire [31:0]             NV_CFG_WORD,
  input  wire [31:0]             NV_LOCK_WORD,
  input  wire [31:0]             NV_REGION_WORD,
  output reg                     ACK,
  output reg                     ALLOW,
  output reg  [31:0]             RDATA,
  output reg                     MEM_WE,
  output reg  [6:0]              MEM_BLOCK,
  output reg  [31:0]             MEM_WDATA,
  output wire                    LOGIN_COUNTER_EN,
  output wire [2:0]              LOGIN_LIMIT_MAX,
  output wire [31:0]             CFG_WORD,
  output wire [31:0]             LOCK_WORD,
  output wire [31:0]             REGION_WORD
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  localparam [31:0] REGION_RESET_WORD = `REGION_RESET;

  reg  [31:0] cfg_q;
  reg  [31:0] lock_q;
  reg  [31:0] region_q;
  reg  [7:0]  region_active_q;
  reg         power_flag_q;
  reg         load_pending_q;

  reg  [31:0] cfg_d;
  reg  [31:0] lock_d;
  reg         allow_d;
  reg  [31:0] rdata_d;
  reg         mem_we_d;
  reg         cfg_we_d;
  reg         lock_we_d;
  reg         region_we_d;

  // ----------------------------------------
  // Address classification
  // ----------------------------------------
  wire [7:0] perma_mask = (LARGE_MEM != 0) ? `CFG_PERMA_LARGE_MASK : `CFG_PERMA_SHORT_MASK;

  wire       in_user   = (REQ_BLOCK >= `USER_FIRST_BLOCK) && (REQ_BLOCK <= `USER_LAST_BLOCK); // RL1
  wire       in_mapped = (REQ_BLOCK >= `MAPPED_FIRST_BLOCK) && (REQ_BLOCK <= `USER_LAST_BLOCK); // RL2
  wire       in_group  = (REQ_BLOCK >= `GROUP_FIRST_BLOCK) && (REQ_BLOCK <= `USER_LAST_BLOCK);

  wire [4:0] quad      = REQ_BLOCK[6:2];
  wire [4:0] group_idx = quad - 5'h4;
  wire [4:0] share_idx = quad - 5'h1;

  wire       group_locked = in_group && lock_q[group_idx[3:0]]; // RL13
  wire       share_wlock  = in_user && UHF_SIDE_WRITE_SHARE_LOCK[share_idx];
  wire       share_rlock  = in_user && UHF_SIDE_READ_SHARE_LOCK[share_idx];

  // ----------------------------------------
  // Password region, value loaded at power-up
  // ----------------------------------------
  wire       region_exempt = region_active_q[7];
  wire [6:0] region_start  = region_active_q[6:0]; // RL18

  wire       pwd_zone = !HF_SECURE && (REQ_BLOCK >= region_start) // RL18
                        && !(region_exempt && in_mapped); // RL17
  wire       pwd_block_wr = pwd_zone; // RL19
  wire       pwd_block_rd = pwd_zone && PROTECT_READ_WRITE_SELECT; // RL19

  assign LOGIN_COUNTER_EN = |LOGIN_FAILURE_LIMIT; // RL5
  assign LOGIN_LIMIT_MAX  = LOGIN_FAILURE_LIMIT; // RL5

  // ----------------------------------------
  // Configuration word read view
  // ----------------------------------------
  wire [31:0] cfg_view = {power_flag_q, cfg_q[30:24] & perma_mask[6:0], // RL8
                          cfg_q[23:16],
                          KILLED, 7'h00, // RL7
                          cfg_q[7:0]};

  // ----------------------------------------
  // Merge of an HF write into the configuration word
  // ----------------------------------------
  function [31:0] merge_cfg;
    input [31:0] old;
    input [31:0] wr;
    input [7:0]  pmask;
    integer      p;
    reg   [31:0] r;
    begin
      r = old;
      for (p = 0; p < 4; p = p + 1) begin
        if (old[2*p +: 2] == 2'b00) begin
          r[2*p +: 2] = wr[2*p +: 2]; // RL6
        end
      end
      r[15:8]  = 8'h00; // RL7
      r[23:16] = wr[23:16];
      r[31]    = 1'b0;
      r[30:24] = (old[30:24] | wr[30:24]) & pmask[6:0]; // RL11
      merge_cfg = r;
    end
  endfunction

  // ----------------------------------------
  // Merge of an HF write into the group lock word
  // ----------------------------------------
  function [31:0] merge_lock;
    input [31:0] old;
    input [31:0] wr;
    integer      i;
    reg   [31:0] r;
    begin
      r = old;
      for (i = 0; i < 16; i = i + 1) begin
        if (!old[16 + i/2]) begin
          r[i] = old[i] | wr[i]; // RL14
        end
      end
      r[23:16] = old[23:16] | wr[23:16]; // RL12
      r[31:24] = 8'h00;
      merge_lock = r;
    end
  endfunction

  // ----------------------------------------
  // Access decision
  // ----------------------------------------
  always @* begin
    allow_d     = 1'b0;
    rdata_d     = 32'h0000_0000;
    mem_we_d    = 1'b0;
    cfg_we_d    = 1'b0;
    lock_we_d   = 1'b0;
    region_we_d = 1'b0;
    cfg_d       = cfg_q;
    lock_d      = lock_q;
    if (REQ) begin
      if (in_user) begin
        if (REQ_WRITE) begin
          if (REQ_UHF) begin
            allow_d = !share_wlock; // RL3 RL20
          end else begin
            allow_d = !group_locked && !pwd_block_wr; // RL3 RL21
          end
          mem_we_d = allow_d; // RL21
        end else begin
          if (REQ_UHF) begin
            allow_d = !share_rlock; // RL20
          end else begin
            allow_d = !pwd_block_rd; // RL19
          end
        end
      end else begin
        case (REQ_BLOCK)
          `CFG_WORD_BLOCK: begin
            if (REQ_WRITE) begin
              allow_d  = !REQ_UHF && HF_SECURE && (LOGIN_FAILURE_LIMIT != 3'b000); // RL4
              cfg_we_d = allow_d;
              cfg_d    = merge_cfg(cfg_q, REQ_WDATA, perma_mask);
            end else begin
              allow_d = 1'b1;
              rdata_d = {1'b1, cfg_view[30:0]}; // RL10
            end
          end
          `LOCK_WORD_BLOCK: begin
            if (REQ_WRITE) begin
              allow_d   = !REQ_UHF;
              lock_we_d = allow_d;
              lock_d    = merge_lock(lock_q, REQ_WDATA);
            end else begin
              allow_d = 1'b1;
              rdata_d = lock_q;
            end
          end
          `REGION_WORD_BLOCK: begin
            if (REQ_WRITE) begin
              if (REQ_UHF) begin
                allow_d = !CFG0_SHARE_WRITE_LOCK; // RL16
              end else begin
                allow_d = !CONFIG_WORDS_LOCK;
              end
              region_we_d = allow_d;
            end else begin
              allow_d = 1'b1;
              rdata_d = region_q;
            end
          end
          default: begin
            allow_d = 1'b0;
          end
        endcase
      end
    end
  end

  // ----------------------------------------
  // Answer and memory write strobe
  // ----------------------------------------
  always @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      ACK       <= 1'b0;
      ALLOW     <= 1'b0;
      RDATA     <= 32'h0000_0000;
      MEM_WE    <= 1'b0;
      MEM_BLOCK <= 7'h00;
      MEM_WDATA <= 32'h0000_0000;
    end else begin
      ACK    <= REQ;
      ALLOW  <= allow_d;
      RDATA  <= allow_d ? rdata_d : 32'h0000_0000;
      MEM_WE <= mem_we_d; // RL21
      if (mem_we_d) begin
        MEM_BLOCK <= REQ_BLOCK;
        MEM_WDATA <= REQ_WDATA;
      end
    end
  end

  // ----------------------------------------
  // Stored words, loaded from non-volatile copy after power-up
  // ----------------------------------------
  always @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      load_pending_q  <= 1'b1;
      cfg_q           <= `CFG_RESET;
      lock_q          <= `LOCK_RESET;
      region_q        <= `REGION_RESET;
      region_active_q <= REGION_RESET_WORD[31:24];
    end else if (load_pending_q) begin
      load_pending_q  <= 1'b0;
      cfg_q           <= {1'b0, NV_CFG_WORD[30:24] & perma_mask[6:0], NV_CFG_WORD[23:16], 8'h00, NV_CFG_WORD[7:0]};
      lock_q          <= {8'h00, NV_LOCK_WORD[23:0]};
      region_q        <= NV_REGION_WORD;
      region_active_q <= NV_REGION_WORD[`REGION_EXEMPT_BIT:`REGION_START_LO]; // RL15
    end else begin
      if (cfg_we_d) begin
        cfg_q <= cfg_d;
      end
      if (lock_we_d) begin
        lock_q <= lock_d; // RL12
      end
      if (region_we_d) begin
        region_q <= REQ_WDATA; // RL15
      end
    end
  end

  // ----------------------------------------
  // Far-field power indicator
  // ----------------------------------------
  always @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      power_flag_q <= 1'b0; // RL9
    end else if (REQ && !REQ_WRITE && (REQ_BLOCK == `CFG_WORD_BLOCK)) begin
      power_flag_q <= 1'b1; // RL10
    end
  end

  assign CFG_WORD    = cfg_view;
  assign LOCK_WORD   = lock_q;
  assign REGION_WORD = region_q;

endmodule

// File: sim/memory_lock_sva.sv
`timescale 1ns/1ns
// ---------------------
// Access checker
// ---------------------
module memory_lock_sva #(
  parameter SHARE_GROUPS = 19
) (
  input wire                    SYS_CLK,
  input wire                    RESET_N,
  input wire                    REQ,
  input wire                    REQ_UHF,
  input wire                    REQ_WRITE,
  input wire [6:0]              REQ_BLOCK,
  input wire                    HF_SECURE,
  input wire [2:0]              LOGIN_FAILURE_LIMIT,
  input wire [SHARE_GROUPS-1:0] UHF_SIDE_WRITE_SHARE_LOCK,
  input wire                    ACK,
  input wire                    ALLOW,
  input wire                    MEM_WE,
  input wire [6:0]              MEM_BLOCK,
  input wire                    LOGIN_COUNTER_EN,
  input wire [31:0]             CFG_WORD,
  input wire [31:0]             LOCK_WORD
);
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (!RESET_N);
  wire [6:0] grp    = (REQ_BLOCK - 7'h04) >> 2;
  wire       uhf_wr = REQ && REQ_UHF && REQ_WRITE && REQ_BLOCK >= 7'h04 && REQ_BLOCK <= 7'h4F;
  wire       cfg_wr = REQ && !REQ_UHF && REQ_WRITE && REQ_BLOCK == 7'h50;
  a_ack_follows_req: assert property (REQ |=> ACK)
    else $error("request not answered");
  a_no_stray_pulse: assert property (!REQ |=> !ACK && !MEM_WE)
    else $error("pulse without request");
  a_we_user_range: assert property (MEM_WE |-> ALLOW && MEM_BLOCK >= 7'h04 && MEM_BLOCK <= 7'h4F)
    else $error("write outside user area");
  a_lock_one_way: assert property ((LOCK_WORD & $past(LOCK_WORD)) == $past(LOCK_WORD))
    else $error("lock bit cleared");
  a_uhf_share_block: assert property (uhf_wr && UHF_SIDE_WRITE_SHARE_LOCK[grp] |=> !ALLOW && !MEM_WE)
    else $error("UHF write passed share lock");
  a_uhf_free_write: assert property (uhf_wr && !UHF_SIDE_WRITE_SHARE_LOCK[grp] |=> ALLOW && MEM_WE)
    else $error("UHF write refused without share lock");
  a_cfg_write_gate: assert property (cfg_wr && !(HF_SECURE && |LOGIN_FAILURE_LIMIT) |=> ACK && !ALLOW)
    else $error("config write granted");
  a_power_flag_set: assert property (REQ && !REQ_WRITE && REQ_BLOCK == 7'h50 |=> CFG_WORD[31] [*2])
    else $error("power flag not set by read");
  a_login_enable: assert property (LOGIN_COUNTER_EN == (LOGIN_FAILURE_LIMIT != 3'h0))
    else $error("login counter enable wrong");
  c_uhf_write: cover property (uhf_wr);
  c_refused: cover property (ACK && !ALLOW);
  c_user_write: cover property (MEM_WE);
endmodule
bind dual_interface_memory_lock memory_lock_sva #(.SHARE_GROUPS(SHARE_GROUPS)) memory_lock_sva_i (
  .SYS_CLK(SYS_CLK), .RESET_N(RESET_N), .REQ(REQ), .REQ_UHF(REQ_UHF), .REQ_WRITE(REQ_WRITE),
  .REQ_BLOCK(REQ_BLOCK), .HF_SECURE(HF_SECURE), .LOGIN_FAILURE_LIMIT(LOGIN_FAILURE_LIMIT),
  .UHF_SIDE_WRITE_SHARE_LOCK(UHF_SIDE_WRITE_SHARE_LOCK), .ACK(ACK), .ALLOW(ALLOW), .MEM_WE(MEM_WE),
  .MEM_BLOCK(MEM_BLOCK), .LOGIN_COUNTER_EN(LOGIN_COUNTER_EN), .CFG_WORD(CFG_WORD), .LOCK_WORD(LOCK_WORD));

// File: sim/rf_reader_model.sv
`timescale 1ns/1ns
// ---------------------
// Reader access model
// ---------------------
module rf_reader_model (
  input  wire        clk,
  input  wire        ack,
  input  wire        allow,
  input  wire        we,
  input  wire [31:0] rdata,
  output reg         req,
  output reg         req_uhf,
  output reg         req_write,
  output reg  [6:0]  req_block,
  output reg  [31:0] req_wdata
);
  initial begin
    {req, req_uhf, req_write, req_block} = 10'h000;
    req_wdata = 32'h0;
  end
  task access(input u, w, input [6:0] b, input [31:0] d, output [2:0] res, output [31:0] rd);
    begin
      @(posedge clk);
      req <= 1'b1;
      req_uhf <= u;
      req_write <= w;
      req_block <= b;
      req_wdata <= d;
      @(posedge clk);
      req <= 1'b0;
      // Released lines lose the last value
      req_block <= ~b;
      req_wdata <= ~d;
      @(negedge clk);
      res = {ack, allow, we};
      rd = rdata;
    end
  endtask
endmodule

// File: sim/tb_dual_interface_memory_lock.sv
`timescale 1ns/1ns
module tb_dual_interface_memory_lock;
  reg         sys_clk, reset_n, secure, sel, cwl, killed, c0l;
  reg  [2:0]  limit;
  reg  [18:0] wshare, rshare;
  reg  [31:0] nv_region, rd;
  wire        req, req_uhf, req_write, ack, allow, mem_we, cnt_en;
  wire [6:0]  req_block, mem_block;
  wire [2:0]  lim_max;
  wire [31:0] req_wdata, rdata, mem_wdata, cfg_word, lock_word, region_word;
  integer     mismatches, tests_run;
  dual_interface_memory_lock #(.LARGE_MEM(0), .SHARE_GROUPS(19)) dual_interface_memory_lock_i (
    .SYS_CLK(sys_clk), .RESET_N(reset_n), .REQ(req), .REQ_UHF(req_uhf), .REQ_WRITE(req_write),
    .REQ_BLOCK(req_block), .REQ_WDATA(req_wdata), .HF_SECURE(secure), .LOGIN_FAILURE_LIMIT(limit),
    .PROTECT_READ_WRITE_SELECT(sel), .CONFIG_WORDS_LOCK(cwl), .KILLED(killed),
    .UHF_SIDE_WRITE_SHARE_LOCK(wshare), .UHF_SIDE_READ_SHARE_LOCK(rshare), .CFG0_SHARE_WRITE_LOCK(c0l),
    .NV_CFG_WORD(32'h0), .NV_LOCK_WORD(32'h0), .NV_REGION_WORD(nv_region), .ACK(ack), .ALLOW(allow),
    .RDATA(rdata), .MEM_WE(mem_we), .MEM_BLOCK(mem_block), .MEM_WDATA(mem_wdata), .LOGIN_COUNTER_EN(cnt_en),
    .LOGIN_LIMIT_MAX(lim_max), .CFG_WORD(cfg_word), .LOCK_WORD(lock_word), .REGION_WORD(region_word));
  rf_reader_model rf_reader_model_i (.clk(sys_clk), .ack(ack), .allow(allow), .we(mem_we), .rdata(rdata),
    .req(req), .req_uhf(req_uhf), .req_write(req_write), .req_block(req_block), .req_wdata(req_wdata));
  // ---------------------
  // Tasks and sequence
  // ---------------------
  task chk(input string n, input [31:0] e, g);
    begin
      tests_run = tests_run + 1;
      if (g !== e) begin
        mismatches = mismatches + 1;
        $display("MISMATCH %0s exp %h got %h", n, e, g);
      end
    end
  endtask
  task op(input u, w, input [6:0] b, input [31:0] d, input ea);
    reg [2:0] r;
    begin
      rf_reader_model_i.access(u, w, b, d, r, rd);
      chk("resp", {29'h0, 1'b1, ea, ea & w & (b >= 7'h04) & (b <= 7'h4F)}, {29'h0, r});
    end
  endtask
  task pwr(input integer n);
    begin
      @(posedge sys_clk) reset_n <= 1'b0;
      repeat (n) @(posedge sys_clk);
      chk("power", 32'h0, {31'h0, cfg_word[31]});
      chk("region", 32'hFF00_0000, region_word);
      @(posedge sys_clk) reset_n <= 1'b1;
      repeat (2) @(posedge sys_clk);
    end
  endtask
  task stop_test;
    begin
      if (mismatches == 0 && tests_run > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
    end
  endtask
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  initial begin
    repeat (3000) @(posedge sys_clk);
    mismatches = mismatches + 1;
    stop_test;
  end
  initial begin
    {secure, sel, cwl, killed, c0l, limit} = 8'h00;
    {wshare, rshare} = 38'h0;
    mismatches = 0;
    tests_run = 0;
    reset_n = 1'b0;
    nv_region = 32'h2000_0000;
    pwr(12);
    op(0, 1, 7'h10, 32'h1234_5678, 1);
    chk("mdata", 32'h1234_5678, mem_wdata);
    chk("mblock", 32'h0000_0010, {25'h0, mem_block});
    op(0, 1, 7'h20, 32'h1, 0);
    op(0, 1, 7'h1F, 32'h2, 1);
    op(0, 0, 7'h30, 32'h0, 1);
    @(posedge sys_clk) sel <= 1'b1;
    op(0, 0, 7'h30, 32'h0, 0);
    op(0, 1, 7'h44, 32'h3, 0);
    op(1, 1, 7'h44, 32'h4, 1);
    @(posedge sys_clk) wshare <= 19'h1_0000;
    op(1, 1, 7'h44, 32'h5, 0);
    @(posedge sys_clk) rshare <= 19'h1_0000;
    op(1, 0, 7'h44, 32'h0, 0);
    op(0, 1, 7'h02, 32'h6, 0);
    chk("cnt_en", 32'h0, {31'h0, cnt_en});
    op(0, 1, 7'h50, 32'hFC00_FF4C, 0);
    @(posedge sys_clk) secure <= 1'b1;
    op(0, 1, 7'h50, 32'hFC00_FF4C, 0);
    @(posedge sys_clk) limit <= 3'h3;
    op(0, 1, 7'h50, 32'hFC00_FF4C, 1);
    chk("cfg", 32'h7C00_004C, cfg_word);
    op(0, 1, 7'h50, 32'h0055_0082, 1);
    chk("cfg", 32'h7C55_004E, cfg_word);
    @(posedge sys_clk) killed <= 1'b1;
    op(0, 0, 7'h50, 32'h0, 1);
    chk("rdata", 32'hFC55_804E, rd);
    op(0, 1, 7'h51, 32'h2, 1);
    op(0, 1, 7'h14, 32'h7, 0);
    op(1, 1, 7'h14, 32'h8, 1);
    op(0, 1, 7'h51, 32'h0001_0000, 1);
    op(0, 1, 7'h51, 32'h1, 1);
    chk("lock", 32'h0001_0002, lock_word);
    @(posedge sys_clk) cwl <= 1'b1;
    op(0, 1, 7'h52, 32'hA000_0000, 0);
    op(1, 1, 7'h52, 32'hA000_0000, 1);
    chk("region", 32'hA000_0000, region_word);
    @(posedge sys_clk) c0l <= 1'b1;
    op(1, 1, 7'h52, 32'h0, 0);
    @(posedge sys_clk) secure <= 1'b0;
    op(0, 1, 7'h44, 32'h9, 0);
    @(posedge sys_clk) nv_region <= 32'hA000_0000;
    pwr(2);
    chk("cnt_en", 32'hB, {28'h0, cnt_en, lim_max});
    op(0, 1, 7'h44, 32'hA, 1);
    op(0, 1, 7'h30, 32'hB, 0);
    stop_test;
  end
endmodule
